// ### rtl/rsps_pkg.sv
// constants shared by the reset and sleep power gating block
package rsps_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned EXT_MIN_PULSE_NS = 1500;
  localparam logic [7:0] EXT_MIN_CYC =
    8'((EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // start-up delay selected by the fuses, in clock cycles
  localparam int DLY_W = 13;
  localparam logic [DLY_W-1:0] DLY_SEL0_CYC = 13'h0004;
  localparam logic [DLY_W-1:0] DLY_SEL1_CYC = 13'h0040;
  localparam logic [DLY_W-1:0] DLY_SEL2_CYC = 13'h0200;
  localparam logic [DLY_W-1:0] DLY_SEL3_CYC = 13'h1000;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_WAKE = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;

  // ==========================================================
  // control register fields and reset values
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ADC_EN_BIT = 3;
  localparam int CTRL_ACMP_EN_BIT = 4;
  localparam int CTRL_ACMP_BG_BIT = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_RST = 8'h00;

  // ==========================================================
  // status register fields
  localparam int STAT_VREF_BIT = 0;
  localparam int STAT_BUF_GATED_BIT = 1;
  localparam int STAT_EXT_CONV_BIT = 2;
  localparam int STAT_BOD_BIT = 3;
  localparam int STAT_WDT_BIT = 4;
  localparam int STAT_ACMP_BIT = 5;

  // ==========================================================
  // sleep mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC_NR = 3'h1;
  localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
  localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;

  // reset sequencer states
  typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} rsps_state_t;

endpackage : rsps_pkg

// ### rtl/rsps_sync.sv
// three-stage pin synchroniser with agreement filter, one per bit
`timescale 1ns/100ps
`default_nettype none
module rsps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ==========================================================
  // per-bit chain
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
          s1 <= INIT[i];
          s2 <= INIT[i];
          s3 <= INIT[i];
          sync_out[i] <= INIT[i];
        end else begin
          s1 <= async_in[i];
          s2 <= s1;
          s3 <= s2;
          // only a level seen twice counts
          if (s2 == s3) begin
            sync_out[i] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule : rsps_sync
`default_nettype wire

// ### rtl/rsps_delay_cnt.sv
// reset stretch counter: counts to the selected timeout, restartable
`timescale 1ns/100ps
`default_nettype none
module rsps_delay_cnt
  import rsps_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // control
  input wire logic restart_in,
  input wire logic [DLY_W-1:0] target_in,
  output logic done_out
);

  logic [DLY_W-1:0] cnt;

  // ==========================================================
  // counter
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || restart_in) begin
      cnt <= '0;
      done_out <= 1'b0;
    end else if (!done_out) begin
      cnt <= DLY_W'(cnt + 1'b1);
      done_out <= (DLY_W'(cnt + 1'b1) == target_in);
    end
  end

endmodule : rsps_delay_cnt
`default_nettype wire

// ### rtl/rsps_reset_sleep.sv
// reset sequencer and sleep power gating controller
//
// How it works
// [R1] any reset loads io registers with initial values; restart at vector
// [R2] io reset asserts immediately from raw sources, without any clock
// [R3] internal reset stretched by delay set by the start-up fuses
// [R4] power-on, external, watchdog and brown-out each assert reset
// [R5] power-on reset holds while supply is below power-on threshold
// [R6] external pin low beyond minimum pulse length gives external reset
// [R7] watchdog expiry resets only while watchdog is enabled
// [R8] brown-out resets while detector enabled and supply is low
// [R9] watchdog reset is a one-cycle pulse; its end starts the delay
// [R10] an enabled converter stays powered in every sleep mode
// [R11] converter re-enabled means the next conversion is extended
// [R12] comparator switched off in sleep modes beyond idle and noise-red
// [R13] fuse-enabled brown-out detector stays on in every sleep mode
// [R14] an enabled watchdog keeps running in every sleep mode
// [R15] reference on when detector, comparator or converter need it
// [R16] software waits for reference start-up after turning it back on
// [R17] input buffers off when both io and converter clocks stop
// [R18] wake-up pins keep their input buffers on in deep sleep
// [R19] internal reset is OR of sources, released on timeout, synchronous
// [R20] a source reappearing during the stretch restarts the delay
`timescale 1ns/100ps
`default_nettype none
module rsps_reset_sleep
  import rsps_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // reset sources
  input wire logic supply_below_por_in,
  input wire logic ext_reset_n_in,
  input wire logic wdt_timeout_in,
  input wire logic wdt_enable_in,
  input wire logic bod_supply_low_in,
  // fuses
  input wire logic brownout_detector_enable_fuse_in,
  input wire logic [1:0] startup_delay_select_fuses_in,
  // core status
  input wire logic sleep_in,
  input wire logic adc_conv_start_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // reset outputs
  output logic io_reset_out,
  output logic core_reset_out,
  output logic fetch_reset_vector_out,
  // power and clock gating
  output logic adc_power_out,
  output logic adc_extended_conv_out,
  output logic acomp_power_out,
  output logic bod_power_out,
  output logic wdt_power_out,
  output logic vref_power_out,
  output logic peripheral_io_clock_run_out,
  output logic converter_clock_run_out,
  output logic [7:0] input_buffer_en_out
);

  // ==========================================================
  // declarations
  logic [5:0] sync_q;
  logic ext_pin_s, por_low_s, bod_low_s, bod_fuse_s;
  logic [1:0] dly_sel_s;
  logic [7:0] ext_low_cnt;
  logic ext_src, por_src, bod_src, any_src, async_src;
  logic wdt_to_q, wdt_rst_pulse;
  rsps_state_t state, next_state;
  logic dly_restart, dly_done, reg_rst;
  logic [DLY_W-1:0] dly_target;
  logic [7:0] ctrl, wake_mask;
  logic [2:0] mode;
  logic adc_en, acmp_en, acmp_bg, adc_en_q, deep_sleep;
  logic next_io_clk, next_conv_clk, next_acomp, next_vref, next_buf_gate;

  // ==========================================================
  // pin synchronisers (fuses are static but still cross in)
  rsps_sync #(
    .W(6),
    .INIT(6'h07)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .async_in({startup_delay_select_fuses_in,
               brownout_detector_enable_fuse_in,
               bod_supply_low_in, supply_below_por_in, ext_reset_n_in}),
    .sync_out(sync_q)
  );

  assign ext_pin_s = sync_q[0];
  assign por_low_s = sync_q[1];
  assign bod_low_s = sync_q[2];
  assign bod_fuse_s = sync_q[3];
  assign dly_sel_s = sync_q[5:4];

  // ==========================================================
  // reset sources
  assign por_src = por_low_s; // [R5]
  assign bod_src = bod_fuse_s & bod_low_s; // [R8]
  assign ext_src = (ext_low_cnt == EXT_MIN_CYC); // [R6]
  assign any_src = por_src | ext_src | bod_src | wdt_rst_pulse; // [R4] [R19]

  // short pin glitches are filtered; only a held low counts
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || ext_pin_s) begin
      ext_low_cnt <= 8'h00;
    end else if (ext_low_cnt != EXT_MIN_CYC) begin
      ext_low_cnt <= 8'(ext_low_cnt + 8'h01); // [R6]
    end
  end

  // watchdog: one pulse per timeout edge, gated by its enable
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      wdt_to_q <= 1'b0;
      wdt_rst_pulse <= 1'b0;
    end else begin
      wdt_to_q <= wdt_timeout_in;
      wdt_rst_pulse <= wdt_timeout_in & ~wdt_to_q & wdt_enable_in; // [R7] [R9]
    end
  end

  // ==========================================================
  // asynchronous io reset
  // raw pins feed the async set so ports clear with no clock running
  assign async_src = supply_below_por_in | ~ext_reset_n_in |
                     (brownout_detector_enable_fuse_in & bod_supply_low_in);

  always_ff @(posedge core_clk_in or posedge async_src) begin
    if (async_src) begin
      io_reset_out <= 1'b1; // [R2]
    end else if (!resetn_in) begin
      io_reset_out <= 1'b1;
    end else begin
      io_reset_out <= (next_state != ST_RUN); // [R1]
    end
  end

  // ==========================================================
  // delay select and stretch counter
  always_comb begin
    unique case (dly_sel_s)
      2'h0: dly_target = DLY_SEL0_CYC;
      2'h1: dly_target = DLY_SEL1_CYC;
      2'h2: dly_target = DLY_SEL2_CYC;
      2'h3: dly_target = DLY_SEL3_CYC;
    endcase
  end

  // the counter runs only while every source is quiet
  assign dly_restart = (state != ST_STRETCH) | any_src; // [R9] [R20]

  rsps_delay_cnt u_dly (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .restart_in(dly_restart),
    .target_in(dly_target),
    .done_out(dly_done)
  );

  // ==========================================================
  // reset sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_HOLD: begin
        if (!any_src) begin
          next_state = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        if (any_src) begin
          next_state = ST_HOLD; // [R20]
        end else if (dly_done) begin
          next_state = ST_RUN; // [R3] [R19]
        end
      end
      ST_RUN: begin
        if (any_src) begin
          next_state = ST_HOLD; // [R19]
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state <= ST_HOLD;
      core_reset_out <= 1'b1;
      fetch_reset_vector_out <= 1'b0;
    end else begin
      state <= next_state;
      core_reset_out <= (next_state != ST_RUN); // [R19]
      fetch_reset_vector_out <= (state != ST_RUN) &&
                                (next_state == ST_RUN); // [R1]
    end
  end

  // ==========================================================
  // registers; the internal reset clears them like any io register
  assign reg_rst = !resetn_in || core_reset_out; // [R1]
  assign mode = ctrl[CTRL_MODE_LSB +: 3];
  assign adc_en = ctrl[CTRL_ADC_EN_BIT];
  assign acmp_en = ctrl[CTRL_ACMP_EN_BIT];
  assign acmp_bg = ctrl[CTRL_ACMP_BG_BIT];

  always_ff @(posedge core_clk_in) begin
    if (reg_rst) begin
      ctrl <= CTRL_RST;
      wake_mask <= WAKE_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADR_CTRL) begin
        ctrl <= {2'h0, reg_wdata_in[5:0]};
      end
      if (reg_addr_in == ADR_WAKE) begin
        wake_mask <= reg_wdata_in;
      end
    end
  end

  // read data stand for the one cycle after the strobe only
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADR_CTRL: reg_rdata_out <= ctrl;
        ADR_WAKE: reg_rdata_out <= wake_mask;
        ADR_STATUS: begin
          reg_rdata_out <= 8'h00;
          reg_rdata_out[STAT_VREF_BIT] <= vref_power_out; // [R16]
          reg_rdata_out[STAT_BUF_GATED_BIT] <= next_buf_gate;
          reg_rdata_out[STAT_EXT_CONV_BIT] <= adc_extended_conv_out;
          reg_rdata_out[STAT_BOD_BIT] <= bod_power_out;
          reg_rdata_out[STAT_WDT_BIT] <= wdt_power_out;
          reg_rdata_out[STAT_ACMP_BIT] <= acomp_power_out;
        end
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ==========================================================
  // sleep gating
  assign deep_sleep = sleep_in && (mode != MODE_IDLE) &&
                      (mode != MODE_ADC_NR);
  assign next_io_clk = !sleep_in || (mode == MODE_IDLE);
  assign next_conv_clk = !sleep_in || (mode == MODE_IDLE) ||
                         (mode == MODE_ADC_NR);
  assign next_buf_gate = !next_io_clk && !next_conv_clk; // [R17]
  assign next_acomp = acmp_en && !deep_sleep; // [R12]
  // reference follows its three users; deep sleep drops it only by switching off the comparator
  assign next_vref = bod_fuse_s | (next_acomp & acmp_bg) | adc_en; // [R15]

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      adc_power_out <= 1'b0;
      acomp_power_out <= 1'b0;
      bod_power_out <= 1'b0;
      wdt_power_out <= 1'b0;
      vref_power_out <= 1'b0;
      peripheral_io_clock_run_out <= 1'b1;
      converter_clock_run_out <= 1'b1;
    end else begin
      adc_power_out <= adc_en; // [R10]
      acomp_power_out <= next_acomp; // [R12]
      bod_power_out <= bod_fuse_s; // [R13]
      wdt_power_out <= wdt_enable_in; // [R14]
      vref_power_out <= next_vref; // [R15]
      peripheral_io_clock_run_out <= next_io_clk;
      converter_clock_run_out <= next_conv_clk;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_buf
      always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
          input_buffer_en_out[i] <= 1'b1;
        end else begin
          input_buffer_en_out[i] <= !next_buf_gate || wake_mask[i]; // [R17] [R18]
        end
      end
    end
  endgenerate

  // ==========================================================
  // extended conversion flag; a new enable beats a start clearing it
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      adc_en_q <= 1'b0;
      adc_extended_conv_out <= 1'b0;
    end else begin
      adc_en_q <= adc_en;
      if (adc_en && !adc_en_q) begin
        adc_extended_conv_out <= 1'b1; // [R11]
      end else if (adc_conv_start_in) begin
        adc_extended_conv_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // assertions
  a_io_reset_async: assert property (@(posedge core_clk_in) // [R2]
    disable iff (!resetn_in) async_src |-> io_reset_out)
    else $error("io reset not asserted by a raw source");
  a_source_holds_core: assert property (@(posedge core_clk_in) // [R4]
    disable iff (!resetn_in) any_src |=> core_reset_out && state == ST_HOLD)
    else $error("active source did not hold internal reset");
  a_por_reset: assert property (@(posedge core_clk_in) // [R5]
    disable iff (!resetn_in) por_low_s |=> core_reset_out)
    else $error("power-on reset missing");
  a_ext_min_pulse: assert property (@(posedge core_clk_in) // [R6]
    disable iff (!resetn_in) $rose(ext_src) |-> $past(!ext_pin_s, 1) &&
    $past(ext_low_cnt) == 8'(EXT_MIN_CYC - 8'h01))
    else $error("external reset taken before minimum pulse");
  a_wdt_gate: assert property (@(posedge core_clk_in) // [R7]
    disable iff (!resetn_in) wdt_rst_pulse |-> $past(wdt_enable_in))
    else $error("watchdog reset while watchdog disabled");
  a_bod_reset: assert property (@(posedge core_clk_in) // [R8]
    disable iff (!resetn_in) (bod_fuse_s && bod_low_s) |=> core_reset_out)
    else $error("brown-out reset missing");
  a_wdt_one_cycle: assert property (@(posedge core_clk_in) // [R9]
    disable iff (!resetn_in) wdt_rst_pulse |=> !wdt_rst_pulse ##1
    (state == ST_STRETCH || $past(any_src)))
    else $error("watchdog pulse not one cycle or no stretch");
  a_release_timeout: assert property (@(posedge core_clk_in) // [R3]
    disable iff (!resetn_in) $fell(core_reset_out) |->
    $past(dly_done) && $past(state) == ST_STRETCH && fetch_reset_vector_out)
    else $error("reset released before delay timeout");
  a_restart_delay: assert property (@(posedge core_clk_in) // [R20]
    disable iff (!resetn_in) (state == ST_STRETCH && any_src) |=>
    state == ST_HOLD ##1 !dly_done)
    else $error("delay not restarted by new source");
  a_adc_in_sleep: assert property (@(posedge core_clk_in) // [R10]
    disable iff (!resetn_in) (adc_en && sleep_in) |=> adc_power_out)
    else $error("converter switched off by sleep");
  a_ext_conv_flag: assert property (@(posedge core_clk_in) // [R11]
    disable iff (!resetn_in) (adc_en && !adc_en_q) |=> adc_extended_conv_out)
    else $error("extended conversion not flagged");
  a_acomp_deep_off: assert property (@(posedge core_clk_in) // [R12]
    disable iff (!resetn_in) deep_sleep |=> !acomp_power_out)
    else $error("comparator left on in deep sleep");
  a_vref_users: assert property (@(posedge core_clk_in) // [R15]
    disable iff (!resetn_in) vref_power_out ==
    (bod_power_out || adc_power_out || (acomp_power_out && $past(acmp_bg))))
    else $error("reference does not follow its users");
  a_buf_wake_pin: assert property (@(posedge core_clk_in) // [R18]
    disable iff (!resetn_in) (wake_mask != 8'h00) |=>
    (input_buffer_en_out & $past(wake_mask)) == $past(wake_mask))
    else $error("wake pin buffer disabled");

endmodule : rsps_reset_sleep
`default_nettype wire

// ### verif/rsps_far_model.sv
// far-side model: supply monitors, external reset pin and watchdog
`timescale 1ns/100ps
`default_nettype none
module rsps_far_model (
  // clock
  input wire logic core_clk_in,
  // reset sources toward the block
  output logic supply_below_por_out,
  output logic ext_reset_n_out,
  output logic wdt_timeout_out,
  output logic wdt_enable_out,
  output logic bod_supply_low_out
);
  initial begin
    supply_below_por_out = 1'b0;
    ext_reset_n_out = 1'b1;
    wdt_timeout_out = 1'b0;
    wdt_enable_out = 1'b0;
    bod_supply_low_out = 1'b0;
  end

  // ==========================================================
  // supply monitors
  task automatic set_supply(input logic por, input logic bod);
    @(posedge core_clk_in);
    supply_below_por_out <= por;
    bod_supply_low_out <= bod;
  endtask : set_supply

  // ==========================================================
  // reset pin, held low a whole number of cycles
  task automatic pin_pulse(input int cycles);
    @(posedge core_clk_in);
    ext_reset_n_out <= 1'b0;
    repeat (cycles) @(posedge core_clk_in);
    ext_reset_n_out <= 1'b1;
  endtask : pin_pulse

  // ==========================================================
  // watchdog: one expiry of its period
  task automatic wdt_expire(input logic enable);
    @(posedge core_clk_in);
    wdt_enable_out <= enable;
    wdt_timeout_out <= 1'b1;
    @(posedge core_clk_in);
    wdt_timeout_out <= 1'b0;
  endtask : wdt_expire
endmodule : rsps_far_model
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the reset and sleep power gating block
`timescale 1ns/100ps
`default_nettype none
module tb
  import rsps_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic resetn_in, fuse, sleep_in, conv, reg_wr_in, reg_rd_in;
  logic [1:0] dsel;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, buf_en;
  logic por, ext_n, wdt_to, wdt_en, bod_low;
  logic io_reset_out, core_reset_out, fetch_reset_vector_out;
  logic adc_pw, ext_conv, acmp_pw, bod_pw, wdt_pw, vref_pw, io_clk, cv_clk;
  logic deep;
  logic [2:0] modes [5] = '{MODE_IDLE, MODE_ADC_NR, MODE_PWR_DOWN,
    MODE_PWR_SAVE, MODE_STANDBY};
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 core_clk_in = ~core_clk_in;

  rsps_far_model far (.core_clk_in(core_clk_in),
    .supply_below_por_out(por), .ext_reset_n_out(ext_n),
    .wdt_timeout_out(wdt_to), .wdt_enable_out(wdt_en),
    .bod_supply_low_out(bod_low));

  rsps_reset_sleep uut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .supply_below_por_in(por), .ext_reset_n_in(ext_n),
    .wdt_timeout_in(wdt_to), .wdt_enable_in(wdt_en),
    .bod_supply_low_in(bod_low), .brownout_detector_enable_fuse_in(fuse),
    .startup_delay_select_fuses_in(dsel), .sleep_in(sleep_in),
    .adc_conv_start_in(conv), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .io_reset_out(io_reset_out), .core_reset_out(core_reset_out),
    .fetch_reset_vector_out(fetch_reset_vector_out),
    .adc_power_out(adc_pw), .adc_extended_conv_out(ext_conv),
    .acomp_power_out(acmp_pw), .bod_power_out(bod_pw),
    .wdt_power_out(wdt_pw), .vref_power_out(vref_pw),
    .peripheral_io_clock_run_out(io_clk),
    .converter_clock_run_out(cv_clk), .input_buffer_en_out(buf_en));

  // ==========================================================
  // checking and register access
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string w);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, e, w);
  endtask : rd

  task automatic wait_edges(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : wait_edges

  // sources must already be quiet; measures the stretch
  task automatic rel(input int tgt);
    int n;
    n = 0;
    while (core_reset_out !== 1'b0 && n < 6000) begin
      wait_edges(1);
      n++;
    end
    chk(8'(n >= tgt && n <= tgt + 12), 8'h01, "stretch");
    chk(io_reset_out, 8'h00, "io reset released");
    chk(fetch_reset_vector_out, 8'h01, "vector fetch");
    wait_edges(1);
    chk(fetch_reset_vector_out, 8'h00, "vector pulse");
  endtask : rel

  // cut a hang short
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end

  // ==========================================================
  // test sequence
  initial begin
    resetn_in = 1'b0;
    fuse = 1'b0;
    dsel = 2'h0;
    sleep_in = 1'b0;
    conv = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    repeat (3) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    rel(DLY_SEL0_CYC);
    rd(ADR_CTRL, CTRL_RST, "ctrl reset");
    rd(ADR_WAKE, WAKE_RST, "wake reset");
    rd(8'h10, 8'h00, "unmapped");
    wr(ADR_CTRL, 8'hC8);
    rd(ADR_CTRL, 8'h08, "ctrl readback");
    // power-on, then a second dip during the stretch
    @(posedge core_clk_in);
    dsel <= 2'h1;
    far.set_supply(1'b1, 1'b0);
    #1;
    chk(io_reset_out, 8'h01, "io reset async");
    wait_edges(5);
    chk(core_reset_out, 8'h01, "por");
    chk(reg_rdata_out, 8'h00, "rdata idle");
    far.set_supply(1'b0, 1'b0);
    wait_edges(30);
    far.set_supply(1'b1, 1'b0);
    wait_edges(5);
    far.set_supply(1'b0, 1'b0);
    rel(DLY_SEL1_CYC);
    rd(ADR_CTRL, CTRL_RST, "ctrl cleared");
    @(posedge core_clk_in);
    dsel <= 2'h0;
    // external pin, too short then long enough
    far.pin_pulse(20);
    wait_edges(8);
    chk(core_reset_out, 8'h00, "short pin");
    far.pin_pulse(int'(EXT_MIN_CYC) + 20);
    wait_edges(1);
    chk(core_reset_out, 8'h01, "long pin");
    rel(DLY_SEL0_CYC);
    // watchdog, disabled then enabled
    far.wdt_expire(1'b0);
    wait_edges(5);
    chk(core_reset_out, 8'h00, "wdt off");
    far.wdt_expire(1'b1);
    wait_edges(2);
    chk(core_reset_out, 8'h01, "wdt reset");
    rel(DLY_SEL0_CYC);
    // brown-out, detector off then on
    far.set_supply(1'b0, 1'b1);
    wait_edges(5);
    chk(core_reset_out, 8'h00, "bod off");
    @(posedge core_clk_in);
    fuse <= 1'b1;
    wait_edges(5);
    chk(core_reset_out, 8'h01, "bod reset");
    far.set_supply(1'b0, 1'b0);
    rel(DLY_SEL0_CYC);
    // every sleep mode with all modules asked for
    wr(ADR_WAKE, 8'h5A);
    sleep_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(ADR_CTRL, 8'h38 | {5'h00, modes[i]});
      wait_edges(3);
      deep = modes[i] != MODE_IDLE && modes[i] != MODE_ADC_NR;
      chk(adc_pw, 8'h01, "adc power");
      chk(acmp_pw, {7'h00, !deep}, "comparator");
      chk(bod_pw, 8'h01, "bod power");
      chk(wdt_pw, 8'h01, "wdt power");
      chk(vref_pw, 8'h01, "vref");
      chk(cv_clk, {7'h00, !deep}, "conv clock");
      chk(buf_en, deep ? 8'h5A : 8'hFF, "buffers");
      chk(io_clk, {7'h00, modes[i] == MODE_IDLE}, "io clock");
    end
    // reference follows its users only
    @(posedge core_clk_in);
    fuse <= 1'b0;
    wr(ADR_CTRL, 8'h30 | {5'h00, MODE_PWR_DOWN});
    wait_edges(3);
    chk(vref_pw, 8'h00, "vref off deep");
    @(posedge core_clk_in);
    sleep_in <= 1'b0;
    wait_edges(3);
    chk(vref_pw, 8'h01, "vref comparator");
    rd(ADR_STATUS, 8'h35, "status reference ready");
    wr(ADR_CTRL, 8'h10);
    wait_edges(3);
    chk(vref_pw, 8'h00, "vref unused");
    // extended conversion after re-enable
    wr(ADR_CTRL, 8'h08);
    @(posedge core_clk_in);
    conv <= 1'b1;
    @(posedge core_clk_in);
    conv <= 1'b0;
    wait_edges(3);
    chk(ext_conv, 8'h00, "conv cleared");
    wr(ADR_CTRL, 8'h00);
    wr(ADR_CTRL, 8'h08);
    wait_edges(3);
    chk(ext_conv, 8'h01, "extended");
    summarize();
  end
endmodule : tb
`default_nettype wire
